// >>> common/apd_pkg.sv
/*
 * Constants for the active power datapath: decimation, filters, pulse
 * conversion. Assumes one clock drives the modulators and the datapath.
 */
package apd_pkg;
   // ****************************************
   // Clocking
   // ****************************************
   localparam int OSC_NOMINAL_HZ = 450000;
   localparam int CLK_HZ = 125000000;
   // ****************************************
   // Decimation
   // ****************************************
   localparam int DEC_RATIO = 64;
   localparam int DEC_CNT_W = 6;
   localparam int CIC_W = 20;
   localparam int SAMPLE_W = 24;
   localparam int SAMPLE_SHIFT = 4;
   // ****************************************
   // Filters and product
   // ****************************************
   localparam int HPF_SHIFT = 10;
   localparam int HPF_ACC_W = 36;
   localparam int HP_W = 25;
   localparam int PROD_W = 49;
   localparam int LPF_SHIFT = 8;
   localparam int LPF_W = 52;
   localparam int POWER_SHIFT = 15;
   localparam int POWER_W = 32;
   // ****************************************
   // Pulse conversion
   // ****************************************
   localparam int ACC_W = 48;
   localparam logic [5:0] F_EXP_BASE = 6'h29;
   localparam logic [5:0] CF_LOG2_BASE = 6'h06;
   localparam logic [5:0] CF_LOG2_MAX = 6'h0B;
   localparam int PULSE_CNT_W = 11;
   localparam logic [PULSE_CNT_W-1:0] F_PULSE_CYCLES = 11'h400;
   localparam logic [PULSE_CNT_W-1:0] CF_PULSE_CYCLES = 11'h040;
endpackage

// >>> core/sinc_decimator.sv
/*
 * Third-order comb decimator turning a one-bit modulator stream into
 * signed samples. Assumes one modulator bit per clock.
 */
`timescale 1ns/100ps
module sinc_decimator
   import apd_pkg::*;
(
   input wire logic clk_i,                          // Datapath clock
   input wire logic rst_i,                          // Async reset, high
   input wire logic bit_i,                          // Modulator bit
   output logic signed [SAMPLE_W-1:0] sample_o,     // Decimated sample
   output logic valid_o                             // Sample strobe
);
   logic signed [CIC_W-1:0] int1, int2, int3, dly1, dly2, dly3;
   logic [DEC_CNT_W-1:0] cnt;
   wire signed [CIC_W-1:0] in_val = bit_i ? 20'sh00001 : -20'sh00001;
   wire signed [CIC_W-1:0] comb1 = int3 - dly1;
   wire signed [CIC_W-1:0] comb2 = comb1 - dly2;
   wire signed [CIC_W-1:0] comb3 = comb2 - dly3;
   wire dump = (cnt == DEC_CNT_W'(DEC_RATIO - 1));

   // ****************************************
   // Integrators and decimated combs
   // ****************************************
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         int1 <= '0;
         int2 <= '0;
         int3 <= '0;
         dly1 <= '0;
         dly2 <= '0;
         dly3 <= '0;
         cnt <= '0;
         sample_o <= '0;
         valid_o <= 1'b0;
      end else begin
         int1 <= int1 + in_val;
         int2 <= int2 + int1;
         int3 <= int3 + int2;
         cnt <= cnt + 1'b1;
         valid_o <= dump;
         if (dump) begin
            dly1 <= int3;
            dly2 <= comb1;
            dly3 <= comb2;
            sample_o <= SAMPLE_W'(comb3) <<< SAMPLE_SHIFT;
         end
      end
   end
endmodule // sinc_decimator

// >>> core/active_power_datapath.sv
/*
 * Active power datapath: decimation, current high-pass, multiply,
 * power low-pass, and pulse conversion onto energy and calibration outputs.
 * Assumes modulator bits arrive synchronous to CLK_I, one per cycle.
 */
`timescale 1ns/100ps
// Operation
// RULE_01: Each modulator delivers one bit per clock cycle.
// RULE_02: Decimators average the bits into signed 24-bit samples.
// RULE_03: Filtering keeps 40 Hz to 1 kHz, removes out-of-band noise.
// RULE_04: Current samples pass a dc-removing high-pass; voltage does not.
// RULE_05: Each sample period current is multiplied by voltage.
// RULE_06: The product is low-pass filtered to extract active power.
// RULE_07: No power-factor dependent processing; plain multiply works.
// RULE_08: Energy pulses come from long accumulation of active power.
// RULE_09: Calibration pulses come from much shorter accumulation.
// RULE_10: All pulse rates come from clock by digital division.
// RULE_11: Energy outputs emit active-high pulses.
// RULE_12: Rate select picks clock over 2^18, 2^17, 2^16 or 2^15.
// RULE_13: Calibration rate is an integer multiple, at most 2048.
// RULE_14: Accumulators pulse and subtract threshold when the sum reaches it.
// RULE_15: Full-precision signed arithmetic, no overflow at full scale.
module active_power_datapath
   import apd_pkg::*;
(
   input wire logic CLK_I,                          // Datapath clock
   input wire logic SYS_RST_I,                      // Async reset, high
   input wire logic CURRENT_BIT_I,                  // Current modulator bit
   input wire logic VOLTAGE_BIT_I,                  // Voltage modulator bit
   input wire logic RATE_SELECT_LOW_I,              // Rate select bit 0
   input wire logic RATE_SELECT_HIGH_I,             // Rate select bit 1
   output logic ENERGY_PULSE_A_O,                   // Energy pulse, phase a
   output logic ENERGY_PULSE_B_O,                   // Energy pulse, phase b
   output logic CALIBRATION_PULSE_OUT_O,            // Calibration pulse
   output logic signed [POWER_W-1:0] POWER_O,       // Filtered active power
   output logic POWER_VALID_O                       // Power strobe
);
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [ACC_W-1:0] pow2(input logic [5:0] e);
      pow2 = ACC_W'(1) << e;
   endfunction

   // Returns {fire, next accumulator}
   function automatic logic [ACC_W:0] step_acc(input logic signed [ACC_W-1:0] acc,
                                               input logic signed [POWER_W-1:0] pwr,
                                               input logic [ACC_W-1:0] th);
      logic signed [ACC_W-1:0] sum;
      sum = acc + ACC_W'(pwr);
      if (sum < 0)
         step_acc = {1'b0, {ACC_W{1'b0}}};
      else if (sum >= $signed(th))
         step_acc = {1'b1, sum - $signed(th)};
      else
         step_acc = {1'b0, sum};
   endfunction

   // ****************************************
   // Decimation
   // ****************************************
   logic signed [SAMPLE_W-1:0] cur_sample, vol_sample;
   logic cur_valid, vol_valid;

   sinc_decimator u_cur_dec (
      .clk_i(CLK_I),
      .rst_i(SYS_RST_I),
      .bit_i(CURRENT_BIT_I),  // RULE_01
      .sample_o(cur_sample),  // RULE_02
      .valid_o(cur_valid)
   );

   sinc_decimator u_vol_dec (
      .clk_i(CLK_I),
      .rst_i(SYS_RST_I),
      .bit_i(VOLTAGE_BIT_I),
      .sample_o(vol_sample),
      .valid_o(vol_valid)
   );

   // ****************************************
   // Datapath decode
   // ****************************************
   logic signed [HPF_ACC_W-1:0] dc_acc;
   logic signed [HP_W-1:0] hp_out;
   logic signed [SAMPLE_W-1:0] vol_d;
   logic hp_valid;
   logic signed [PROD_W-1:0] prod;
   logic prod_valid;
   logic signed [LPF_W-1:0] lp;
   logic signed [ACC_W-1:0] f_acc, cf_acc;
   logic [1:0] rate_code;
   logic [PULSE_CNT_W-1:0] f_cnt, cf_cnt;
   logic pulse_sel;

   wire signed [HP_W-1:0] dc_est = HP_W'(dc_acc >>> HPF_SHIFT);
   wire signed [HP_W-1:0] next_hp = HP_W'(cur_sample) - dc_est;
   wire signed [PROD_W-1:0] next_prod = PROD_W'(hp_out) * PROD_W'(vol_d);
   wire signed [LPF_W-1:0] next_lp = lp + ((LPF_W'(prod) - lp) >>> LPF_SHIFT);
   wire [5:0] f_exp = F_EXP_BASE - {4'h0, rate_code};
   wire [5:0] cf_ratio_log2 = CF_LOG2_BASE - {4'h0, rate_code};  // RULE_13
   wire [ACC_W-1:0] f_th = pow2(f_exp);
   wire [ACC_W-1:0] cf_th = pow2(f_exp - cf_ratio_log2);
   wire [ACC_W:0] f_step = step_acc(f_acc, POWER_O, f_th);
   wire [ACC_W:0] cf_step = step_acc(cf_acc, POWER_O, cf_th);
   wire f_fire = POWER_VALID_O && f_step[ACC_W];
   wire cf_fire = POWER_VALID_O && cf_step[ACC_W];
   wire f_busy = (f_cnt != '0);
   wire cf_busy = (cf_cnt != '0);

   // ****************************************
   // High-pass, multiply, low-pass
   // ****************************************
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         dc_acc <= '0;
         hp_out <= '0;
         vol_d <= '0;
         hp_valid <= 1'b0;
      end else begin
         hp_valid <= cur_valid;
         if (cur_valid) begin
            dc_acc <= dc_acc + HPF_ACC_W'(next_hp);  // RULE_04
            hp_out <= next_hp;                       // RULE_04
            vol_d <= vol_sample;
         end
      end
   end

   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         prod <= '0;
         prod_valid <= 1'b0;
         lp <= '0;
         POWER_O <= '0;
         POWER_VALID_O <= 1'b0;
      end else begin
         prod_valid <= hp_valid;
         POWER_VALID_O <= prod_valid;
         if (hp_valid)
            prod <= next_prod;  // RULE_05 RULE_07 RULE_15
         if (prod_valid) begin
            lp <= next_lp;  // RULE_06 RULE_03
            POWER_O <= POWER_W'(next_lp >>> POWER_SHIFT);
         end
      end
   end

   // ****************************************
   // Pulse conversion
   // ****************************************
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         rate_code <= 2'h0;
         f_acc <= '0;
         cf_acc <= '0;
      end else begin
         rate_code <= {RATE_SELECT_HIGH_I, RATE_SELECT_LOW_I};  // RULE_12
         if (POWER_VALID_O) begin
            f_acc <= f_step[ACC_W-1:0];   // RULE_08 RULE_14
            cf_acc <= cf_step[ACC_W-1:0]; // RULE_09 RULE_14
         end
      end
   end

   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         f_cnt <= '0;
         cf_cnt <= '0;
         pulse_sel <= 1'b0;
         ENERGY_PULSE_A_O <= 1'b0;
         ENERGY_PULSE_B_O <= 1'b0;
         CALIBRATION_PULSE_OUT_O <= 1'b0;
      end else begin
         if (f_fire && !f_busy) begin
            f_cnt <= F_PULSE_CYCLES - 1'b1;
            pulse_sel <= ~pulse_sel;
            ENERGY_PULSE_A_O <= !pulse_sel;  // RULE_11 RULE_10
            ENERGY_PULSE_B_O <= pulse_sel;   // RULE_11
         end else if (f_busy) begin
            f_cnt <= f_cnt - 1'b1;
         end else begin
            ENERGY_PULSE_A_O <= 1'b0;
            ENERGY_PULSE_B_O <= 1'b0;
         end
         if (cf_fire && !cf_busy) begin
            cf_cnt <= CF_PULSE_CYCLES - 1'b1;
            CALIBRATION_PULSE_OUT_O <= 1'b1;  // RULE_09 RULE_10
         end else if (cf_busy) begin
            cf_cnt <= cf_cnt - 1'b1;
         end else begin
            CALIBRATION_PULSE_OUT_O <= 1'b0;
         end
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);

   a_bit_rate: assert property (cur_valid |-> ##64 cur_valid) // RULE_01
      else $error("sample strobe not every 64 cycles");
   a_channels_aligned: assert property (cur_valid == vol_valid) // RULE_02
      else $error("channel strobes out of step");
   a_hpf_path: assert property (cur_valid |-> ##1 hp_valid ##1 prod_valid ##1 POWER_VALID_O) // RULE_04
      else $error("pipeline strobe lost");
   a_product: assert property (prod_valid |-> prod == $past(hp_out) * $past(vol_d)) // RULE_05
      else $error("product mismatch");
   a_power_range: assert property (POWER_VALID_O |-> // RULE_15
                                   (POWER_O < 32'sh4000_0001 && POWER_O > -32'sh4000_0001))
      else $error("power out of range");
   a_f_acc_bound: assert property (!f_acc[ACC_W-1] && (f_acc < $signed(f_th) || $changed(rate_code) // RULE_14
                                   || $past(rate_code) != rate_code))
      else $error("energy accumulator above threshold");
   a_cf_ratio: assert property (f_th >= cf_th && f_th <= (cf_th << CF_LOG2_MAX)) // RULE_13
      else $error("calibration ratio out of range");
   a_cf_width: assert property ($rose(CALIBRATION_PULSE_OUT_O) |-> ##63 CALIBRATION_PULSE_OUT_O // RULE_09
                                ##1 !CALIBRATION_PULSE_OUT_O)
      else $error("calibration pulse width wrong");
   a_f_exclusive: assert property (!(ENERGY_PULSE_A_O && ENERGY_PULSE_B_O) // RULE_11
                                   and ($rose(ENERGY_PULSE_A_O) |-> f_cnt == F_PULSE_CYCLES - 1'b1))
      else $error("energy pulses overlap or mistimed");
   // Threshold one-hot at bit 41 down to 38 for codes 0 to 3
   a_rate_div: assert property (f_th == {6'h00, rate_code == 2'h0, rate_code == 2'h1, // RULE_12
                                         rate_code == 2'h2, rate_code == 2'h3, 38'h0})
      else $error("rate threshold wrong");

   c_energy_pulse: cover property ($rose(ENERGY_PULSE_B_O));
   c_cal_pulse: cover property ($rose(CALIBRATION_PULSE_OUT_O));
   c_negative_power: cover property (POWER_VALID_O && POWER_O < 0);
   c_fast_rate: cover property (rate_code == 2'h3 && f_fire);
endmodule // active_power_datapath

// >>> testbench/sd_modulator_model.sv
/*
 * First-order sigma-delta modulator model feeding one channel bit stream.
 * Assumes the level input is a signed fraction of 2^15 full scale.
 */
`timescale 1ns/100ps
module sd_modulator_model (
   input wire logic clk_i,                   // Sample clock
   input wire logic rst_i,                   // Async reset, high
   input wire logic signed [15:0] level_i,   // Analog level, scaled
   output logic bit_o                        // Modulator bit
);
   // ****************************************
   // Loop integrator and one-bit quantiser
   // ****************************************
   logic signed [31:0] integ;
   logic signed [31:0] next_integ;
   assign next_integ = integ + 32'(level_i) - (bit_o ? 32'sd32768 : -32'sd32768);
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         integ <= 32'sh0;
         bit_o <= 1'b0;
      end else begin
         integ <= next_integ;
         bit_o <= ~next_integ[31];
      end
   end
endmodule // sd_modulator_model

// >>> testbench/testbench.sv
/*
 * Self-checking bench for the active power datapath: strobe timing,
 * reverse power, forward power pulse outputs. Assumes modulator models.
 */
`timescale 1ns/100ps
module testbench;
   import apd_pkg::*;
   // ****************************************
   // Stimulus and design
   // ****************************************
   localparam logic signed [15:0] AMP = 16'sh7800;
   logic clk, rst, rsl, rsh, flip, bit_i, bit_v, ea, eb, cf, pv;
   logic signed [15:0] lvl_i, lvl_v;
   logic signed [POWER_W-1:0] pwr;
   logic [2:0] pulses, prev;
   int fail_count, n_tests, tick, first_out;
   int rises[3], width[3], run[3];
   active_power_datapath dut_u (.CLK_I(clk), .SYS_RST_I(rst), .CURRENT_BIT_I(bit_i), .VOLTAGE_BIT_I(bit_v),
      .RATE_SELECT_LOW_I(rsl), .RATE_SELECT_HIGH_I(rsh), .ENERGY_PULSE_A_O(ea), .ENERGY_PULSE_B_O(eb),
      .CALIBRATION_PULSE_OUT_O(cf), .POWER_O(pwr), .POWER_VALID_O(pv));
   sd_modulator_model cur_u (.clk_i(clk), .rst_i(rst), .level_i(lvl_i), .bit_o(bit_i));
   sd_modulator_model vol_u (.clk_i(clk), .rst_i(rst), .level_i(lvl_v), .bit_o(bit_v));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Square waves, in phase or inverted
   always @(posedge clk) begin
      tick <= tick + 1;
      lvl_i <= tick[10] ? AMP : -AMP;
      lvl_v <= (tick[10] ^ flip) ? AMP : -AMP;
   end
   // ****************************************
   // Pulse monitor
   // ****************************************
   assign pulses = {cf, eb, ea};
   always @(posedge clk) begin
      prev <= pulses;
      for (int i = 0; i < 3; i++) begin
         if (pulses[i] === 1'b1 && prev[i] !== 1'b1) begin
            rises[i]++;
            run[i] = 1;
            if (first_out == 0 && i < 2) first_out = i + 1;
         end else if (pulses[i] === 1'b1) run[i]++;
         else if (prev[i] === 1'b1) width[i] = run[i];
      end
   end
   // ****************************************
   // Checking and run control
   // ****************************************
   task automatic cmp_bit(input string name, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %b seen %b", name, exp, got);
      end
   endtask
   task automatic cmp_word(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %0d seen %0d", name, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic do_reset();
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      #1 cmp_bit("idle outputs", 1'b0, ea | eb | cf | pv);
      @(posedge clk);
      rst <= 1'b0;
      rises = '{0, 0, 0};
      width = '{0, 0, 0};
      first_out = 0;
   endtask
   task automatic s_strobe_timing();
      int n;
      logic seen;
      n = 0;
      seen = 1'b0;
      while (!seen && n < 200) begin
         @(posedge clk);
         n++;
         #1 seen = (pv === 1'b1);
      end
      cmp_word("first strobe", 67, n);
      repeat (64) @(posedge clk);
      #1 cmp_bit("strobe spacing", 1'b1, pv);
   endtask
   task automatic s_reverse();
      flip <= 1'b1;
      rsl <= 1'b1;
      rsh <= 1'b0;
      do_reset();
      s_strobe_timing();
      // Rate change mid-run with empty accumulators
      @(posedge clk);
      rsl <= 1'b0;
      rsh <= 1'b1;
      repeat (16000) @(posedge clk);
      #1 cmp_bit("reverse sign", 1'b1, pwr[POWER_W-1]);
      cmp_word("reverse cal pulses", 0, rises[2]);
      cmp_word("reverse energy pulses", 0, rises[0] + rises[1]);
   endtask
   task automatic s_forward();
      @(posedge clk);
      flip <= 1'b0;
      rsl <= 1'b1;
      rsh <= 1'b1;
      do_reset();
      repeat (80000) @(posedge clk);
      #1 cmp_bit("forward sign", 1'b0, pwr[POWER_W-1]);
      cmp_bit("cal pulses seen", 1'b1, rises[2] > 0);
      cmp_word("cal width", 64, width[2]);
      cmp_bit("cal ratio", 1'b1, rises[2] >= 8 * (rises[0] + rises[1]));
      cmp_bit("energy pulses seen", 1'b1, rises[0] > 0);
      cmp_word("first energy output", 1, first_out);
      cmp_bit("alternation", 1'b1, (rises[0] - rises[1]) inside {0, 1});
      cmp_word("energy width", 1024, width[0]);
   endtask
   initial begin
      rst = 1'b1;
      rsl = 1'b0;
      rsh = 1'b0;
      flip = 1'b0;
      tick = 0;
      lvl_i = 16'sh0;
      lvl_v = 16'sh0;
      fail_count = 0;
      n_tests = 0;
      s_reverse();
      s_forward();
      conclude();
   end
   initial begin
      #(110000 * 8);
      fail_count++;
      conclude();
   end
endmodule // testbench
